// >>> hdl/vlifd_defs.svh
// Purpose: shared bit positions, widths and reset values of the decoder
// Assumes: included by its bare name from every design file that needs it
// Notes:   positions refer to the assembled 32-bit instruction word, except the halfword opcode and the fetched-word lanes
`ifndef VLIFD_DEFS_SVH
`define VLIFD_DEFS_SVH

// major opcode, always the top six bits
`define VLIFD_OPC_HI      31
`define VLIFD_OPC_LO      26
`define VLIFD_HALF_OPC_HI 15
`define VLIFD_HALF_OPC_LO 10

// fixed positions of the 5-bit register fields
`define VLIFD_RT_HI 25
`define VLIFD_RT_LO 21
`define VLIFD_RS_HI 20
`define VLIFD_RS_LO 16
`define VLIFD_RD_HI 15
`define VLIFD_RD_LO 11
`define VLIFD_RR_HI 10
`define VLIFD_RR_LO 6

// 3-bit register fields of a 16-bit instruction held in bits 31..16
`define VLIFD_R3A_HI 25
`define VLIFD_R3A_LO 23
`define VLIFD_R3B_HI 22
`define VLIFD_R3B_LO 20
`define VLIFD_R3C_HI 19
`define VLIFD_R3C_LO 17

// immediate and minor opcode slots
`define VLIFD_I26_HI 25
`define VLIFD_I16_HI 15
`define VLIFD_I12_HI 11
`define VLIFD_I10_HI 25
`define VLIFD_I10_LO 16
`define VLIFD_MIN12_HI 15
`define VLIFD_MIN12_LO 12
`define VLIFD_MIN16_HI 25
`define VLIFD_MIN16_LO 21
`define VLIFD_MINS_HI 19
`define VLIFD_MINS_LO 16

// halfword lanes of a fetched word
`define VLIFD_UPPER_HI 31
`define VLIFD_UPPER_LO 16
`define VLIFD_LOWER_HI 15
`define VLIFD_LOWER_LO 0

// reset values
`define VLIFD_MODE_RST 1'b0
`define VLIFD_ZERO16   16'h0000

`endif

// >>> hdl/vlifd_fields.sv
// Purpose: field extraction of one assembled instruction
// Assumes: 16-bit instructions arrive in bits 31..16, low half zero
// Notes:   purely combinational; the top registers every output
`timescale 1ns/1ps
`include "vlifd_defs.svh"

module vlifd_fields #(
  parameter logic [63:0] IMM26_MAP = 64'h0000_0000_0000_0000,
  parameter logic [63:0] IMM12_MAP = 64'h0000_0000_0000_0000,
  parameter logic [63:0] COP_MAP   = 64'h0000_0000_0000_0000,
  parameter logic [3:0]  COP_IMPL  = 4'h1,
  parameter logic        CU_AS_RI  = 1'b0
) (
  input  wire logic [31:0]            insn,
  input  wire logic                   is32,
  input  wire logic                   compact,
  output logic [5:0]                  major,
  output logic [4:0]                  rt,
  output logic [4:0]                  rs,
  output logic [4:0]                  rd,
  output logic [4:0]                  rr,
  output logic [2:0]                  r3a,
  output logic [2:0]                  r3b,
  output logic [2:0]                  r3c,
  output vlifd_pkg::vlifd_imm_type    imm_class,
  output logic [25:0]                 imm,
  output logic [4:0]                  minor,
  output logic [31:0]                 boff,
  output logic [27:0]                 joff,
  output logic                        ri,
  output logic                        cu,
  output logic [1:0]                  cu_num
);

  // sign extend a 16-bit offset and scale it to the target alignment
  function automatic logic [31:0] scale_off(input logic [15:0] off, input logic half);
    scale_off = half ? {{15{off[15]}}, off, 1'b0} : {{14{off[15]}}, off, 2'b00};
  endfunction : scale_off

  logic coproc;

  // register fields need no opcode, so they are cut straight out
  always_comb
  begin
    major = insn[`VLIFD_OPC_HI:`VLIFD_OPC_LO];                       // [RQ4]
    rt    = insn[`VLIFD_RT_HI:`VLIFD_RT_LO];                         // [RQ6]
    rs    = insn[`VLIFD_RS_HI:`VLIFD_RS_LO];                         // [RQ6]
    rd    = insn[`VLIFD_RD_HI:`VLIFD_RD_LO];
    rr    = insn[`VLIFD_RR_HI:`VLIFD_RR_LO];
    r3a   = insn[`VLIFD_R3A_HI:`VLIFD_R3A_LO];                       // [RQ5]
    r3b   = insn[`VLIFD_R3B_HI:`VLIFD_R3B_LO];                       // [RQ5]
    r3c   = insn[`VLIFD_R3C_HI:`VLIFD_R3C_LO];                       // [RQ5]
  end

  // immediate class and placement follow the major opcode
  always_comb
  begin
    if (!is32)
      imm_class = vlifd_pkg::IMM_NONE;
    else if (IMM26_MAP[major])
      imm_class = vlifd_pkg::IMM_26;                                 // [RQ9]
    else if (IMM12_MAP[major])
      imm_class = vlifd_pkg::IMM_12;                                 // [RQ9]
    else
      imm_class = vlifd_pkg::IMM_16;
    unique case (imm_class)
      vlifd_pkg::IMM_26:
      begin
        imm   = insn[`VLIFD_I26_HI:0];                               // [RQ10]
        minor = 5'h00;
      end
      vlifd_pkg::IMM_16:
      begin
        imm   = {10'h000, insn[`VLIFD_I16_HI:0]};                    // [RQ11] [RQ7]
        minor = insn[`VLIFD_MIN16_HI:`VLIFD_MIN16_LO];               // [RQ11]
      end
      vlifd_pkg::IMM_12:
      begin
        imm   = {14'h0000, insn[`VLIFD_I12_HI:0]};                   // [RQ12]
        // other fields share this slot; the first-named starts lowest
        minor = {1'b0, insn[`VLIFD_MIN12_HI:`VLIFD_MIN12_LO]};       // [RQ12] [RQ8]
      end
      vlifd_pkg::IMM_NONE:
      begin
        imm   = {16'h0000, insn[`VLIFD_I10_HI:`VLIFD_I10_LO]};       // [RQ7]
        minor = {1'b0, insn[`VLIFD_MINS_HI:`VLIFD_MINS_LO]};
      end
    endcase
  end

  // targets: halfword alignment in compact mode, word alignment otherwise
  always_comb
  begin
    if (is32)
      boff = scale_off(insn[`VLIFD_I16_HI:0], compact);              // [RQ1] [RQ2]
    else
      boff = scale_off({{6{insn[`VLIFD_I10_HI]}},
                        insn[`VLIFD_I10_HI:`VLIFD_I10_LO]}, 1'b1);   // [RQ2]
    joff = compact ? {1'b0, insn[`VLIFD_I26_HI:0], 1'b0}             // [RQ2]
                   : {insn[`VLIFD_I26_HI:0], 2'b00};                 // [RQ1]
  end

  // absent coprocessor: in compact mode the exception kind is fixed when the part is built; legacy mode always raises coprocessor unusable
  always_comb
  begin
    cu_num = major[1:0];
    coproc = is32 && COP_MAP[major] && !COP_IMPL[cu_num];
    ri     = coproc && compact && CU_AS_RI;                          // [RQ3]
    cu     = coproc && !(compact && CU_AS_RI);                       // [RQ3]
  end

endmodule : vlifd_fields

// >>> hdl/vlifd_pkg.sv
// Purpose: types of the variable-length instruction format decoder
// Assumes: nothing beyond the defs header
// Notes:   constants live in vlifd_defs.svh, types live here
package vlifd_pkg;

  // halfword buffer states
  typedef enum logic [2:0] {
    ST_EMPTY,
    ST_FIRST,
    ST_SECOND,
    ST_WAIT_TAIL,
    ST_HAVE_TAIL
  } vlifd_state_type;

  // class of the immediate of the decoded instruction
  typedef enum logic [1:0] {
    IMM_NONE,
    IMM_16,
    IMM_26,
    IMM_12
  } vlifd_imm_type;

  // whole state of the top module
  typedef struct packed {
    vlifd_state_type st;
    logic            mode;
    logic            skip;
    logic [31:0]     word;
    logic [15:0]     pend;
    logic            valid;
    logic [31:0]     insn;
    logic            is32;
    logic            compact;
    logic [5:0]      major;
    logic [4:0]      rt;
    logic [4:0]      rs;
    logic [4:0]      rd;
    logic [4:0]      rr;
    logic [2:0]      r3a;
    logic [2:0]      r3b;
    logic [2:0]      r3c;
    vlifd_imm_type   imm_class;
    logic [25:0]     imm;
    logic [4:0]      minor;
    logic [31:0]     boff;
    logic [27:0]     joff;
    logic            ri;
    logic            cu;
    logic [1:0]      cu_num;
  } vlifd_regs_type;

endpackage : vlifd_pkg

// >>> hdl/vlifd_top.sv
// Purpose: halfword placement, length finding and field decode of fetched words
// Assumes: fetch words are in ascending address order; one clock, async reset
// Notes:   16-bit instructions leave on insn_word[31:16] with the low half zero
//
// What this block does
// RQ1 - legacy mode scales offsets by four
// RQ2 - compact mode scales offsets by two
// RQ3 - absent coprocessor: build-time exception kind choice in compact mode; legacy always coprocessor unusable
// RQ4 - 16 or 32 bits, major opcode on top
// RQ5 - 5-bit fields long, 3-bit fields short
// RQ6 - 5-bit register fields at fixed positions
// RQ7 - immediates taken right-aligned
// RQ8 - extra fields between immediate and minor
// RQ9 - major opcode alone gives length, format
// RQ10 - 26-bit format: opcode 31..26, imm 25..0
// RQ11 - 16-bit format: immediate from 15..0
// RQ12 - 12-bit format: immediate 11..0, minor above
// RQ13 - big endian: first half 31..16
// RQ14 - little endian: first half 15..0
// RQ15 - long instruction built from ordered halfwords
// RQ16 - halfwords consumed in ascending address order
// RQ17 - one-bit mode: 0 legacy, 1 compact
// RQ18 - straddling instruction waits for next word
`timescale 1ns/1ps
`include "vlifd_defs.svh"

module vlifd_top #(
  parameter logic [63:0] LEN16_MAP = 64'h0E0E_0E0E_0E0E_0E0E,
  parameter logic [63:0] IMM26_MAP = 64'h0000_0000_0000_0000,
  parameter logic [63:0] IMM12_MAP = 64'h0000_0000_0000_0000,
  parameter logic [63:0] COP_MAP   = 64'h0000_0000_0000_0000,
  parameter logic [3:0]  COP_IMPL  = 4'h1,
  parameter logic        CU_AS_RI  = 1'b0
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   big_endian,
  input  wire logic                   mode_wr,
  input  wire logic                   mode_wr_value,
  input  wire logic                   flush,
  input  wire logic                   flush_upper,
  input  wire logic                   fetch_valid,
  input  wire logic [31:0]            fetch_word,
  output logic                        fetch_ready,
  output logic                        isa_mode,
  output logic                        insn_valid,
  input  wire logic                   insn_ready,
  output logic [31:0]                 insn_word,
  output logic                        insn_is32,
  output logic                        insn_compact,
  output logic [5:0]                  major_opcode,
  output logic [4:0]                  target_register_field,
  output logic [4:0]                  source_register_field,
  output logic [4:0]                  dest_register_field,
  output logic [4:0]                  fourth_register_field,
  output logic [2:0]                  short_reg_a,
  output logic [2:0]                  short_reg_b,
  output logic [2:0]                  short_reg_c,
  output vlifd_pkg::vlifd_imm_type    imm_class,
  output logic [25:0]                 imm_value,
  output logic [4:0]                  minor_opcode,
  output logic [31:0]                 branch_offset,
  output logic [27:0]                 jump_offset,
  output logic                        reserved_instruction_exception,
  output logic                        cop_unusable_exception,
  output logic [1:0]                  cop_unusable_num
);

  // pick the first (second=0) or following halfword of a fetched word
  function automatic logic [15:0] pick_half(input logic [31:0] w,
                                            input logic        big,
                                            input logic        second);
    if (big ^ second)
      pick_half = w[`VLIFD_UPPER_HI:`VLIFD_UPPER_LO];
    else
      pick_half = w[`VLIFD_LOWER_HI:`VLIFD_LOWER_LO];
  endfunction : pick_half

  // a halfword starts a 32-bit instruction unless its opcode is marked short
  function automatic logic starts_long(input logic [15:0] h);
    starts_long = !LEN16_MAP[h[`VLIFD_HALF_OPC_HI:`VLIFD_HALF_OPC_LO]];
  endfunction : starts_long

  vlifd_pkg::vlifd_regs_type r_reg;
  vlifd_pkg::vlifd_regs_type r_next;

  logic [15:0]              half_first;
  logic [15:0]              half_second;
  logic                     can_load;
  logic                     emit;
  logic [31:0]              cand_insn;
  logic                     cand_is32;
  logic [5:0]               f_major;
  logic [4:0]               f_rt;
  logic [4:0]               f_rs;
  logic [4:0]               f_rd;
  logic [4:0]               f_rr;
  logic [2:0]               f_r3a;
  logic [2:0]               f_r3b;
  logic [2:0]               f_r3c;
  vlifd_pkg::vlifd_imm_type f_imm_class;
  logic [25:0]              f_imm;
  logic [4:0]               f_minor;
  logic [31:0]              f_boff;
  logic [27:0]              f_joff;
  logic                     f_ri;
  logic                     f_cu;
  logic [1:0]               f_cu_num;

  // decode the candidate before it is registered
  vlifd_fields #(
    .IMM26_MAP (IMM26_MAP),
    .IMM12_MAP (IMM12_MAP),
    .COP_MAP   (COP_MAP),
    .COP_IMPL  (COP_IMPL),
    .CU_AS_RI  (CU_AS_RI)
  ) u_fields (
    .insn      (cand_insn),
    .is32      (cand_is32),
    .compact   (r_reg.mode),
    .major     (f_major),
    .rt        (f_rt),
    .rs        (f_rs),
    .rd        (f_rd),
    .rr        (f_rr),
    .r3a       (f_r3a),
    .r3b       (f_r3b),
    .r3c       (f_r3c),
    .imm_class (f_imm_class),
    .imm       (f_imm),
    .minor     (f_minor),
    .boff      (f_boff),
    .joff      (f_joff),
    .ri        (f_ri),
    .cu        (f_cu),
    .cu_num    (f_cu_num)
  );

  // halfword order follows endianness
  assign half_first  = pick_half(r_reg.word, big_endian, 1'b0);      // [RQ13] [RQ14]
  assign half_second = pick_half(r_reg.word, big_endian, 1'b1);      // [RQ13] [RQ14]

  // a new word is only taken while no halfword of the last one is left, or only its straddling half waits in pend;
  // this halves peak rate but keeps the buffer a single word deep
  assign fetch_ready = (r_reg.st == vlifd_pkg::ST_EMPTY ||
                        r_reg.st == vlifd_pkg::ST_WAIT_TAIL) &&
                       !flush && !mode_wr;                           // [RQ16]

  assign can_load = !r_reg.valid || insn_ready;

  // buffer walk, instruction assembly and output loading
  always_comb
  begin
    r_next    = r_reg;
    emit      = 1'b0;
    cand_insn = 32'h0000_0000;
    cand_is32 = 1'b0;
    unique case (r_reg.st)
      vlifd_pkg::ST_EMPTY:
        if (fetch_valid)
        begin
          r_next.word = fetch_word;
          r_next.skip = 1'b0;
          r_next.st   = (r_reg.mode && r_reg.skip) ? vlifd_pkg::ST_SECOND
                                                   : vlifd_pkg::ST_FIRST;
        end
      vlifd_pkg::ST_FIRST:
        if (can_load)
        begin
          emit = 1'b1;
          if (!r_reg.mode)
          begin
            cand_insn = r_reg.word;                                  // [RQ1]
            cand_is32 = 1'b1;
            r_next.st = vlifd_pkg::ST_EMPTY;
          end
          else if (starts_long(half_first))                          // [RQ9]
          begin
            cand_insn = {half_first, half_second};                   // [RQ15]
            cand_is32 = 1'b1;
            r_next.st = vlifd_pkg::ST_EMPTY;
          end
          else
          begin
            cand_insn = {half_first, `VLIFD_ZERO16};                 // [RQ4]
            r_next.st = vlifd_pkg::ST_SECOND;                        // [RQ16]
          end
        end
      vlifd_pkg::ST_SECOND:
        if (can_load)
        begin
          if (starts_long(half_second))
          begin
            r_next.pend = half_second;                               // [RQ18]
            r_next.st   = vlifd_pkg::ST_WAIT_TAIL;
          end
          else
          begin
            emit      = 1'b1;
            cand_insn = {half_second, `VLIFD_ZERO16};
            r_next.st = vlifd_pkg::ST_EMPTY;
          end
        end
      vlifd_pkg::ST_WAIT_TAIL:
        if (fetch_valid)
        begin
          r_next.word = fetch_word;                                  // [RQ18]
          r_next.st   = vlifd_pkg::ST_HAVE_TAIL;
        end
      vlifd_pkg::ST_HAVE_TAIL:
        if (can_load)
        begin
          emit      = 1'b1;
          cand_insn = {r_reg.pend, half_first};                      // [RQ15] [RQ18]
          cand_is32 = 1'b1;
          r_next.st = vlifd_pkg::ST_SECOND;
        end
    endcase

    // register the decoded candidate, or retire the taken one
    if (emit)
    begin
      r_next.valid     = 1'b1;
      r_next.insn      = cand_insn;
      r_next.is32      = cand_is32;
      r_next.compact   = r_reg.mode;
      r_next.major     = f_major;
      r_next.rt        = f_rt;
      r_next.rs        = f_rs;
      r_next.rd        = f_rd;
      r_next.rr        = f_rr;
      r_next.r3a       = f_r3a;
      r_next.r3b       = f_r3b;
      r_next.r3c       = f_r3c;
      r_next.imm_class = f_imm_class;
      r_next.imm       = f_imm;
      r_next.minor     = f_minor;
      r_next.boff      = f_boff;
      r_next.joff      = f_joff;
      r_next.ri        = f_ri;
      r_next.cu        = f_cu;
      r_next.cu_num    = f_cu_num;
    end
    else if (insn_ready)
      r_next.valid = 1'b0;

    // redirect or mode change drops everything buffered
    if (flush || mode_wr)
    begin
      r_next.st    = vlifd_pkg::ST_EMPTY;
      r_next.valid = 1'b0;
      r_next.skip  = flush && flush_upper && !mode_wr;
    end
    if (mode_wr)
      r_next.mode = mode_wr_value;                                   // [RQ17]
  end

  // the one state register; reset leaves the mode at its build value
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r_reg      <= '0;
      r_reg.st   <= vlifd_pkg::ST_EMPTY;
      r_reg.mode <= `VLIFD_MODE_RST;                                 // [RQ17]
    end
    else
      r_reg <= r_next;
  end

  // outputs straight from the state register
  assign isa_mode                       = r_reg.mode;
  assign insn_valid                     = r_reg.valid;
  assign insn_word                      = r_reg.insn;
  assign insn_is32                      = r_reg.is32;
  assign insn_compact                   = r_reg.compact;
  assign major_opcode                   = r_reg.major;
  assign target_register_field          = r_reg.rt;
  assign source_register_field          = r_reg.rs;
  assign dest_register_field            = r_reg.rd;
  assign fourth_register_field          = r_reg.rr;
  assign short_reg_a                    = r_reg.r3a;
  assign short_reg_b                    = r_reg.r3b;
  assign short_reg_c                    = r_reg.r3c;
  assign imm_class                      = r_reg.imm_class;
  assign imm_value                      = r_reg.imm;
  assign minor_opcode                   = r_reg.minor;
  assign branch_offset                  = r_reg.boff;
  assign jump_offset                    = r_reg.joff;
  assign reserved_instruction_exception = r_reg.valid && r_reg.ri;
  assign cop_unusable_exception         = r_reg.valid && r_reg.cu;
  assign cop_unusable_num               = r_reg.cu_num;

  // checks on the registered results
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_legacy_scale: assert property (                                  // [RQ1]
    insn_valid && !insn_compact |->
      branch_offset == {{14{insn_word[15]}}, insn_word[15:0], 2'b00} &&
      jump_offset == {insn_word[25:0], 2'b00})
    else $error("legacy offset not scaled by four");

  a_compact_scale: assert property (                                 // [RQ2]
    insn_valid && insn_compact && insn_is32 |->
      branch_offset == {{15{insn_word[15]}}, insn_word[15:0], 1'b0} &&
      jump_offset == {1'b0, insn_word[25:0], 1'b0})
    else $error("compact offset not scaled by two");

  a_legacy_no_ri: assert property (                                  // [RQ3]
    insn_valid && !insn_compact |-> !reserved_instruction_exception)
    else $error("legacy mode raised reserved instruction");

  a_major_top: assert property (                                     // [RQ4]
    insn_valid |-> major_opcode == insn_word[31:26] &&
      (insn_is32 || insn_word[15:0] == 16'h0000))
    else $error("major opcode not in top bits");

  a_reg_fixed: assert property (                                     // [RQ6]
    insn_valid && insn_is32 |->
      target_register_field == insn_word[25:21] &&
      source_register_field == insn_word[20:16])
    else $error("register field not at fixed place");

  a_legacy_long: assert property (                                   // [RQ9]
    insn_valid && !insn_compact |-> insn_is32 && imm_class != vlifd_pkg::IMM_NONE)
    else $error("legacy instruction decoded short");

  a_imm26_place: assert property (                                   // [RQ10]
    insn_valid && imm_class == vlifd_pkg::IMM_26 |-> imm_value == insn_word[25:0])
    else $error("26-bit immediate misplaced");

  a_tail_hold: assert property (                                     // [RQ18]
    r_reg.st == vlifd_pkg::ST_WAIT_TAIL && !fetch_valid && !flush && !mode_wr |=>
      r_reg.st == vlifd_pkg::ST_WAIT_TAIL && $stable(r_reg.pend) && !insn_valid)
    else $error("straddling half not held");

  a_tail_join: assert property (                                     // [RQ15]
    r_reg.st == vlifd_pkg::ST_HAVE_TAIL && can_load && !flush && !mode_wr |=>
      insn_valid && insn_is32 && insn_word[31:16] == $past(r_reg.pend))
    else $error("tail not joined behind held half");

  a_first_half: assert property (                                    // [RQ13]
    r_reg.st == vlifd_pkg::ST_FIRST && r_reg.mode && can_load &&
      !flush && !mode_wr |=>
      insn_valid && insn_word[31:16] ==
        ($past(big_endian) ? $past(r_reg.word[31:16]) : $past(r_reg.word[15:0])))
    else $error("first halfword taken from wrong lane");

endmodule : vlifd_top

// >>> sim/variable_length_insn_format_decode_tb.sv
// Purpose: self-checking bench of the instruction format decoder
// Assumes: default length map, coprocessor major 5 mapped, only unit 0 present
// Notes:   outputs are judged at a falling edge while they stand
`timescale 1ns/1ps

module variable_length_insn_format_decode_tb;
  logic        clk, rst, big_endian, mode_wr, mode_wr_value, fetch_valid, fetch_ready;
  logic        isa_mode, insn_valid, insn_is32, ri_exc, cu_exc, insn_compact;
  logic        flush, flush_upper, insn_ready;
  logic [31:0] fetch_word, insn_word, branch_offset;
  logic [27:0] jump_offset;
  logic [25:0] imm_f;
  logic [5:0]  major_opcode;
  logic [4:0]  rt_f, rs_f, rd_f, rr_f, minor_f;
  logic [2:0]  sa, sb, sc;
  logic [1:0]  imm_c, cu_n;
  int          err_total, num_checks;

  vlifd_fetch_model fm (.clk(clk), .rst(rst), .fetch_ready(fetch_ready),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word));

  vlifd_top #(.COP_MAP(64'h0000_0000_0000_0020)) uut (.clk(clk), .rst(rst),
    .big_endian(big_endian), .mode_wr(mode_wr), .mode_wr_value(mode_wr_value),
    .flush(flush), .flush_upper(flush_upper), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_ready(fetch_ready), .isa_mode(isa_mode),
    .insn_valid(insn_valid), .insn_ready(insn_ready), .insn_word(insn_word),
    .insn_is32(insn_is32), .insn_compact(insn_compact), .major_opcode(major_opcode),
    .target_register_field(rt_f), .source_register_field(rs_f),
    .dest_register_field(rd_f), .fourth_register_field(rr_f), .short_reg_a(sa),
    .short_reg_b(sb), .short_reg_c(sc), .imm_class(imm_c), .imm_value(imm_f),
    .minor_opcode(minor_f), .branch_offset(branch_offset), .jump_offset(jump_offset),
    .reserved_instruction_exception(ri_exc), .cop_unusable_exception(cu_exc),
    .cop_unusable_num(cu_n));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // offsets scale by two in compact mode, by four in legacy mode
  function automatic logic [31:0] exp_boff(input logic [31:0] w, input logic l, input logic c);
    if (!l)
      return {{21{w[25]}}, w[25:16], 1'h0};
    return c ? {{15{w[15]}}, w[15:0], 1'h0} : {{14{w[15]}}, w[15:0], 2'h0};
  endfunction : exp_boff

  // wait boundedly for the next instruction and judge all of its fields
  task automatic expect_insn(input logic [31:0] w, input logic l, input logic c,
                             input logic cu);
    int i;
    i = 0;
    @(negedge clk);
    while (insn_valid !== 1'h1 && i < 30)
    begin
      @(negedge clk);
      i++;
    end
    check({31'h0, insn_valid}, 32'h1, "insn valid");
    check(insn_word, w, "insn word");
    check({26'h0, major_opcode}, {26'h0, w[31:26]}, "major");
    check({22'h0, rt_f, rs_f}, {22'h0, w[25:16]}, "reg fields");
    check({3'h0, rd_f, rr_f, sa, sb, sc, cu_n, insn_compact, minor_f, imm_c},
          {3'h0, w[15:6], w[25:17], w[27:26], c, l ? w[25:21] : {1'h0, w[19:16]},
           l ? vlifd_pkg::IMM_16 : vlifd_pkg::IMM_NONE}, "fields");
    check({6'h0, imm_f}, l ? {16'h0, w[15:0]} : {22'h0, w[25:16]}, "imm");
    check({31'h0, insn_is32}, {31'h0, l}, "length");
    check(branch_offset, exp_boff(w, l, c), "branch offset");
    check({4'h0, jump_offset}, c ? {5'h0, w[25:0], 1'h0} : {4'h0, w[25:0], 2'h0},
          "jump offset");
    check({30'h0, ri_exc, cu_exc}, {31'h0, cu}, "exceptions");
    @(posedge clk);
  endtask : expect_insn

  task automatic set_mode(input logic v);
    @(posedge clk);
    mode_wr       <= 1'h1;
    mode_wr_value <= v;
    @(posedge clk);
    mode_wr <= 1'h0;
    @(negedge clk);
    check({31'h0, isa_mode}, {31'h0, v}, "isa mode");
  endtask : set_mode

  task automatic test_legacy;
    check({30'h0, isa_mode, insn_valid}, 32'h0, "reset state");
    fm.load(32'h0021_3840);
    fm.load(32'h1400_0000);
    expect_insn(32'h0021_3840, 1'h1, 1'h0, 1'h0);
    expect_insn(32'h1400_0000, 1'h1, 1'h0, 1'h1);
    $display("test legacy done");
  endtask : test_legacy

  // long, three short, straddling long, short, then an absent coprocessor
  task automatic test_compact_big;
    set_mode(1'h1);
    fm.load(32'h0021_3840);
    fm.load(32'h0455_0BAA);
    fm.load(32'h0455_0021);
    fm.load(32'h3840_0BAA);
    fm.load(32'h1400_0000);
    expect_insn(32'h0021_3840, 1'h1, 1'h1, 1'h0);
    expect_insn(32'h0455_0000, 1'h0, 1'h1, 1'h0);
    expect_insn(32'h0BAA_0000, 1'h0, 1'h1, 1'h0);
    expect_insn(32'h0455_0000, 1'h0, 1'h1, 1'h0);
    expect_insn(32'h0021_3840, 1'h1, 1'h1, 1'h0);
    expect_insn(32'h0BAA_0000, 1'h0, 1'h1, 1'h0);
    expect_insn(32'h1400_0000, 1'h1, 1'h1, 1'h1);
    $display("test compact big endian done");
  endtask : test_compact_big

  task automatic test_compact_little;
    big_endian <= 1'h0;
    fm.load(32'h3840_0021);
    fm.load(32'h0BAA_0455);
    expect_insn(32'h0021_3840, 1'h1, 1'h1, 1'h0);
    expect_insn(32'h0455_0000, 1'h0, 1'h1, 1'h0);
    expect_insn(32'h0BAA_0000, 1'h0, 1'h1, 1'h0);
    {flush, flush_upper, insn_ready} <= 3'h6;
    @(posedge clk);
    flush <= 1'h0;
    fm.load(32'h0BAA_0455);
    repeat (4) @(posedge clk);
    insn_ready <= 1'h1;
    expect_insn(32'h0BAA_0000, 1'h0, 1'h1, 1'h0);
    $display("test compact little endian done");
  endtask : test_compact_little

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // free-running core clock at 50 MHz
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // a hang costs a mismatch and ends the run the normal way
  initial
  begin
    #100000;
    err_total++;
    results();
  end

  initial
  begin
    err_total     = 0;
    num_checks    = 0;
    rst           = 1'h1;
    big_endian    = 1'h1;
    mode_wr       = 1'h0;
    mode_wr_value = 1'h0;
    {flush, flush_upper, insn_ready} = 3'h1;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    test_legacy();
    test_compact_big();
    test_compact_little();
    results();
  end
endmodule : variable_length_insn_format_decode_tb

// >>> sim/vlifd_fetch_model.sv
// Purpose: fetch path model that offers queued memory words to the decoder
// Assumes: the bench queues words in ascending address order
// Notes:   an idle word bus inverts its last value every idle cycle, so it toggles
`timescale 1ns/1ps

module vlifd_fetch_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        fetch_ready,
  output logic             fetch_valid,
  output logic [31:0]      fetch_word
);
  logic [31:0] words_q[$];

  // append one word behind those already waiting
  task automatic load(input logic [31:0] w);
    words_q.push_back(w);
  endtask : load

  // head word is held until the edge that sees ready high, then the next follows
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fetch_valid <= 1'h0;
      fetch_word  <= 32'h0000_0000;
    end
    else
    begin
      if (fetch_valid && fetch_ready)
        void'(words_q.pop_front());
      if (words_q.size() > 0)
      begin
        fetch_valid <= 1'h1;
        fetch_word  <= words_q[0];
      end
      else
      begin
        fetch_valid <= 1'h0;
        fetch_word  <= ~fetch_word; // idle lines must not look like a held word
      end
    end
  end
endmodule : vlifd_fetch_model
